// ### src/dam_modifier.sv
// Function
// RQ1: Requests +00001, +97501, -00009 form the digit one increment control.
// RQ2: Requests -00001 and -00021 form the digit one decrement control.
// RQ3: Request -00010 is the digit one no-change control.
// RQ4: Each one-hot quinary position is gated with three controls and ORed.
// RQ5: Fives bit flips only on increment from four or nine or decrement from zero or five.
// RQ6: Digit one fives output follows the documented set cases.
// RQ7: Check bit inverts on change; digit one result parity marks even.
// RQ8: Digit two no-change control derived from digit one and request.
// RQ9: Digit two carry only when digit one is nine under increments.
// RQ10: Digit two borrow under -00009 unless digit one is nine, decrements at zero, or -00010.
// RQ11: Result is stored in output flops and held two microseconds.
// RQ12: Digit two parity bit is gated directly, never decoded.
// RQ13: Under -00021 digit two translates to its value minus two.
// RQ14: Under +97501 digits three and four translate plus five and seven.
// RQ15: Each input digit decodes to one-hot quinary, fives and parity.
// RQ16: The requester raises one request ahead of the modifier strobe; the sync model raises it together with the strobe.
// RQ17: At most one request may be active in any modification cycle.
module dam_modifier
(
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   input  wire logic        MOD_STROBE,
   input  wire logic        REQ_P1,
   input  wire logic        REQ_P97501,
   input  wire logic        REQ_M1,
   input  wire logic        REQ_M9,
   input  wire logic        REQ_M10,
   input  wire logic        REQ_M21,
   input  wire logic [24:0] ADDR_IN,
   output logic      [24:0] MODIFIED_DIGIT_OUT,
   output logic             ADDR_SEND,
   output logic             BUSY
);
   import dam_pkg::*;

   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);

   dam_code_t         digit_one_input;
   logic              second_digit_parity_in;
   logic              minus21_translate_ctl;
   logic              plus97501_ctl;
   logic              inc_grp;
   logic              dec_grp;
   logic              next_digit_no_change;
   logic              next_digit_add_carry;
   logic              next_digit_sub_borrow;
   logic [4:0]        inc_c;
   logic [4:0]        dec_c;
   logic [4:0]        keep_c;
   logic [4:0]        nine;
   logic [4:0]        zero;
   logic [3:0]        pre [DIGITS];
   dam_code_t         res [DIGITS];
   logic [HOLD_W-1:0] hold_cnt;

   ////////////////////////////////////////////////////////////////////////
   // Request grouping and translation controls.
   assign digit_one_input        = ADDR_IN[4:0];
   assign second_digit_parity_in = ADDR_IN[9];
   assign minus21_translate_ctl  = REQ_M21;
   assign plus97501_ctl          = REQ_P97501;
   assign inc_grp                = REQ_P1 | REQ_P97501;
   assign dec_grp                = REQ_M1 | REQ_M21;

   assign pre[0] = PRE_NONE;
   assign pre[1] = minus21_translate_ctl ? PRE_MINUS2 : PRE_NONE; // RQ13
   assign pre[2] = plus97501_ctl ? PRE_PLUS5 : PRE_NONE;          // RQ14
   assign pre[3] = plus97501_ctl ? PRE_PLUS7 : PRE_NONE;          // RQ14
   assign pre[4] = PRE_NONE;

   ////////////////////////////////////////////////////////////////////////
   // Digit one controls and the controls it sends to digit two.
   assign next_digit_no_change  = (dec_grp & ~zero[0])           // RQ8
                                | (REQ_M9 & nine[0])
                                | (inc_grp & ~nine[0]);
   assign next_digit_add_carry  = inc_grp & nine[0];             // RQ9
   assign next_digit_sub_borrow = (REQ_M9 & ~nine[0])            // RQ10
                                | (dec_grp & zero[0])
                                | REQ_M10;

   always_comb
   begin
      inc_c[0]  = inc_grp | REQ_M9;                              // RQ1
      dec_c[0]  = dec_grp;                                       // RQ2
      keep_c[0] = ~inc_c[0] & ~dec_c[0];                         // RQ3
      inc_c[1]  = next_digit_add_carry;
      dec_c[1]  = next_digit_sub_borrow;
      keep_c[1] = next_digit_no_change;
      for (int k = 2; k < DIGITS; k++)
      begin
         inc_c[k]  = inc_c[k-1] & nine[k-1];
         dec_c[k]  = dec_c[k-1] & zero[k-1];
         keep_c[k] = ~inc_c[k] & ~dec_c[k];
      end
      // The nine of the fifth modifying digit turns a carry into no change.
      if (plus97501_ctl)
      begin
         inc_c[4]  = 1'b0;
         keep_c[4] = inc_c[3] & nine[3];
         dec_c[4]  = ~keep_c[4];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Five digit stages.
   for (genvar k = 0; k < DIGITS; k++)
   begin : g_digit
      dam_ctl_if ctl ();
      assign ctl.inc  = inc_c[k];
      assign ctl.dec  = dec_c[k];
      assign ctl.keep = keep_c[k];
      dam_digit u_digit
      (
         .code_in  (k == 1 ? {second_digit_parity_in, ADDR_IN[8:5]}
                           : ADDR_IN[k*CODE_W +: CODE_W]),
         .pre      (pre[k]),
         .ctl      (ctl),
         .code_out (res[k]),
         .is_nine  (nine[k]),
         .is_zero  (zero[k])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Output storage and hold timing.
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
         MODIFIED_DIGIT_OUT <= OUT_RESET;
      else if (MOD_STROBE)                                       // RQ16
         MODIFIED_DIGIT_OUT <= {res[4], res[3], res[2], res[1], res[0]};
   end

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         hold_cnt <= '0;
         BUSY     <= 1'b0;
      end
      else if (MOD_STROBE)
      begin
         hold_cnt <= HOLD_LAST;                                  // RQ11
         BUSY     <= 1'b1;
      end
      else if (BUSY)
      begin
         if (hold_cnt == '0)
            BUSY <= 1'b0;
         else
            hold_cnt <= hold_cnt - 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
         ADDR_SEND <= 1'b0;
      else
         ADDR_SEND <= BUSY & (hold_cnt == '0) & ~MOD_STROBE;     // RQ11
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   dam_val_t d1_in;
   dam_val_t d2_in;
   assign d1_in = dam_decode(digit_one_input);
   assign d2_in = dam_decode(ADDR_IN[9:5]);

   // Cycles since the last strobe, kept apart from the hold counter.
   logic [9:0] since_strobe;

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
         since_strobe <= '0;
      else if (MOD_STROBE)
         since_strobe <= '0;
      else if (since_strobe != '1)
         since_strobe <= since_strobe + 10'h001;
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   a_incr_digit_one: assert property (MOD_STROBE && inc_c[0] |=> // RQ1
      dam_decode(MODIFIED_DIGIT_OUT[4:0]) == (($past(d1_in) == VAL_NINE)
         ? VAL_ZERO : 4'($past(d1_in) + 4'h1)))
      else $error("Digit one not incremented.");
   a_decr_digit_one: assert property (MOD_STROBE && dec_c[0] |=> // RQ2
      dam_decode(MODIFIED_DIGIT_OUT[4:0]) == (($past(d1_in) == VAL_ZERO)
         ? VAL_NINE : 4'($past(d1_in) - 4'h1)))
      else $error("Digit one not decremented.");
   a_keep_digit_one: assert property (MOD_STROBE && REQ_M10 |=> // RQ3
      MODIFIED_DIGIT_OUT[3:0] == $past(ADDR_IN[3:0]))
      else $error("Digit one changed under no change.");
   a_fives_inc_out: assert property (MOD_STROBE && inc_c[0] |=> // RQ6
      MODIFIED_DIGIT_OUT[3] == ($past(d1_in) >= 4'h4
                                && $past(d1_in) <= 4'h8))
      else $error("Digit one fives output wrong.");
   a_check_flip: assert property (MOD_STROBE && !keep_c[0] |=> // RQ7
      MODIFIED_DIGIT_OUT[4] != $past(ADDR_IN[4]))
      else $error("Check bit not inverted on change.");
   a_no_change_ctl: assert property (inc_grp && d1_in != VAL_NINE |-> // RQ8
      next_digit_no_change && !next_digit_add_carry)
      else $error("Digit two control wrong under increment.");
   a_carry_cause: assert property (next_digit_add_carry |-> // RQ9
      inc_grp && d1_in == VAL_NINE)
      else $error("Carry without cause.");
   a_borrow_m10: assert property (REQ_M10 |-> next_digit_sub_borrow) // RQ10
      else $error("No borrow under minus ten.");
   a_hold_send: assert property ($rose(ADDR_SEND) |-> // RQ11
      since_strobe == 10'(HOLD_CYC) && $stable(MODIFIED_DIGIT_OUT))
      else $error("Send not after hold time.");
   a_minus21_digit: assert property (MOD_STROBE && REQ_M21 // RQ13
      && d1_in != VAL_ZERO |=> dam_decode(MODIFIED_DIGIT_OUT[9:5])
         == 4'(({1'b0, $past(d2_in)} + 5'h8) % 5'hA))
      else $error("Digit two not lowered by two.");

   c_carry_out: cover property (MOD_STROBE && next_digit_add_carry);
   c_minus21: cover property (MOD_STROBE && REQ_M21);
   c_plus97501: cover property (MOD_STROBE && REQ_P97501);
   c_send: cover property (ADDR_SEND);
   c_carry_five: cover property (MOD_STROBE && plus97501_ctl && keep_c[4]);

endmodule: dam_modifier

// ### src/dam_pkg.sv
package dam_pkg;

   localparam int          DIGITS        = 5;
   localparam int          CODE_W        = 5;
   localparam int          HOLD_NS       = 2000;
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
   localparam int          HOLD_W        = $clog2(HOLD_CYC);
   localparam logic [3:0]  PRE_NONE      = 4'h0;
   localparam logic [3:0]  PRE_MINUS2    = 4'h8;
   localparam logic [3:0]  PRE_PLUS5     = 4'h5;
   localparam logic [3:0]  PRE_PLUS7     = 4'h7;
   localparam logic [3:0]  VAL_NINE      = 4'h9;
   localparam logic [3:0]  VAL_ZERO      = 4'h0;
   localparam logic [3:0]  VAL_FIVE      = 4'h5;
   localparam logic [3:0]  VAL_TEN       = 4'hA;
   localparam logic [24:0] OUT_RESET     = 25'h0000000;

   typedef logic [CODE_W-1:0] dam_code_t;
   typedef logic [3:0]        dam_val_t;

   // Decimal value of a five-bit digit code, parity bit ignored.
   function automatic dam_val_t dam_decode(input dam_code_t c);
      dam_val_t q;
      case (c[2:0])
         3'h1:    q = 4'h1;
         3'h2:    q = 4'h2;
         3'h7:    q = 4'h3;
         3'h6:    q = 4'h4;
         default: q = 4'h0;
      endcase
      return c[3] ? 4'(q + VAL_FIVE) : q;
   endfunction: dam_decode

   // Digit code from one-hot quinary, fives and parity.
   function automatic dam_code_t dam_encode(input logic [4:0] q,
                                            input logic       f,
                                            input logic       p);
      logic [2:0] b;
      b = 3'h0;
      if (q[1])
         b = 3'h1;
      else if (q[2])
         b = 3'h2;
      else if (q[3])
         b = 3'h7;
      else if (q[4])
         b = 3'h6;
      return {p, f, b};
   endfunction: dam_encode

endpackage: dam_pkg

// ### src/dam_ctl_if.sv
interface dam_ctl_if;
   logic inc;
   logic dec;
   logic keep;
   modport src (output inc, output dec, output keep);
   modport dst (input inc, input dec, input keep);
endinterface: dam_ctl_if

// ### src/dam_digit.sv
module dam_digit
(
   input  wire dam_pkg::dam_code_t code_in,
   input  wire logic [3:0]         pre,
   dam_ctl_if.dst                  ctl,
   output dam_pkg::dam_code_t      code_out,
   output logic                    is_nine,
   output logic                    is_zero
);
   import dam_pkg::*;

   dam_val_t   raw;
   logic [4:0] sum;
   dam_val_t   val;
   logic [4:0] q;
   logic [4:0] next_q;
   logic       fives;
   logic       next_fives;
   logic       next_par;

   ////////////////////////////////////////////////////////////////////////
   // Translation, with the deliberate offset applied on the way in.
   assign raw   = dam_decode(code_in);                    // RQ15
   assign sum   = {1'b0, raw} + {1'b0, pre};               // RQ13 RQ14
   assign val   = (sum >= {1'b0, VAL_TEN}) ? 4'(sum - {1'b0, VAL_TEN})
                                           : sum[3:0];
   assign fives = (val >= VAL_FIVE);
   assign q     = 5'h01 << (fives ? 4'(val - VAL_FIVE) : val);

   ////////////////////////////////////////////////////////////////////////
   // Modification by add one, subtract one or no change.
   always_comb
   begin
      for (int i = 0; i < 5; i++)
      begin
         next_q[i] = (ctl.keep & q[i])                     // RQ4
                   | (ctl.inc & q[(i + 4) % 5])
                   | (ctl.dec & q[(i + 1) % 5]);
      end
   end

   assign next_fives = fives ^ ((ctl.inc & q[4])           // RQ5 RQ6
                              | (ctl.dec & q[0]));
   // The parity bit bypasses decoding and flips on change or odd offset, but not on both together.
   assign next_par   = code_in[4] ^ pre[0] ^ ~ctl.keep;    // RQ7 RQ12
   assign code_out   = dam_encode(next_q, next_fives, next_par);
   assign is_nine    = fives & q[4];
   assign is_zero    = ~fives & q[0];

endmodule: dam_digit

// ### tb/dam_sync_model.sv
module dam_sync_model
(
   input  wire logic        SYS_CLK,
   output logic             MOD_STROBE,
   output logic      [5:0]  req,
   output logic      [24:0] ADDR_IN
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      MOD_STROBE = 1'b0;
      req        = 6'h00;
      ADDR_IN    = 25'h0000000;
   end

   ////////////////////////////////////////////////////////////////////////
   // One request is raised with the strobe for one cycle, then released.
   task automatic issue(input int k, input logic [24:0] a);
      @(posedge SYS_CLK);
      #1;
      MOD_STROBE = 1'b1;
      req        = 6'(1 << k);
      ADDR_IN    = a;
      @(posedge SYS_CLK);
      #1;
      MOD_STROBE = 1'b0;
      req        = 6'h00;
      ADDR_IN    = ~a;
   endtask: issue
endmodule: dam_sync_model

// ### tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] QT [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h6};
   logic        SYS_CLK = 1'b0;
   logic        RSTN    = 1'b0;
   logic        MOD_STROBE;
   logic [5:0]  req;
   logic [24:0] ADDR_IN;
   logic [24:0] MODIFIED_DIGIT_OUT;
   logic        ADDR_SEND;
   logic        BUSY;
   int          n_fail      = 0;
   int          check_count = 0;
   int          cyc         = 0;

   always #2 SYS_CLK = ~SYS_CLK;

   dam_modifier dam_modifier_i (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
      .MOD_STROBE(MOD_STROBE), .REQ_P1(req[0]), .REQ_P97501(req[1]),
      .REQ_M1(req[2]), .REQ_M9(req[3]), .REQ_M10(req[4]),
      .REQ_M21(req[5]), .ADDR_IN(ADDR_IN),
      .MODIFIED_DIGIT_OUT(MODIFIED_DIGIT_OUT), .ADDR_SEND(ADDR_SEND),
      .BUSY(BUSY));
   dam_sync_model dam_sync_model_i (.SYS_CLK(SYS_CLK),
      .MOD_STROBE(MOD_STROBE), .req(req), .ADDR_IN(ADDR_IN));

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask: stop_test

   task automatic check(input logic [24:0] seen, input logic [24:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask: check

   always @(posedge SYS_CLK)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_fail++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Digit codes from decimal digits, and the expected modified address.
   function automatic logic [24:0] enc(input logic [19:0] a);
      logic [24:0] r;
      logic [3:0]  d;
      for (int i = 0; i < 5; i++)
      begin
         d = a[4*i +: 4];
         r[5*i +: 5] = {~d[0], d >= 4'h5, QT[d % 5]};
      end
      return r;
   endfunction: enc

   function automatic logic [19:0] exp_mod(input int k, input logic [19:0] a);
      int          d;
      int          c;
      int          v;
      int          p;
      logic [19:0] r;
      d = a[3:0];
      c = (k < 2 || k == 3) ? 1 : (k == 2 || k == 5) ? -1 : 0;
      r[3:0] = 4'((d + c + 10) % 10);
      c = (k < 2 && d == 9) ? 1 :
          ((k == 3 && d != 9) || (c < 0 && d == 0) || k == 4) ? -1 : 0;
      for (int i = 1; i < 5; i++)
      begin
         p = (i == 1 && k == 5) ? 8 : (k == 1 && i > 1 && i < 4) ? 2*i+1 : 0;
         v = (a[4*i +: 4] + p) % 10;
         if (k == 1 && i == 4)
            c = (c > 0) ? 0 : -1;
         r[4*i +: 4] = 4'((v + c + 10) % 10);
         c = (c > 0 && v == 9) ? 1 : (c < 0 && v == 0) ? -1 : 0;
      end
      return r;
   endfunction: exp_mod

   ////////////////////////////////////////////////////////////////////////
   task automatic do_mod(input int k, input logic [19:0] a);
      int          n;
      logic [24:0] e;
      e = enc(exp_mod(k, a));
      dam_sync_model_i.issue(k, enc(a));
      check(MODIFIED_DIGIT_OUT, e);
      check(MODIFIED_DIGIT_OUT >> 5, e >> 5);
      check(25'(BUSY), 25'h1);
      n = 0;
      while (ADDR_SEND !== 1'b1 && n < 600)
      begin
         @(posedge SYS_CLK);
         #1;
         n++;
      end
      check(25'(n), 25'h1F4);
      check(25'(BUSY), 25'h0);
      @(posedge SYS_CLK);
      #1;
      check(25'(ADDR_SEND), 25'h0);
   endtask: do_mod

   task automatic quiet(input int len);
      int n;
      n = 0;
      repeat (len)
      begin
         @(posedge SYS_CLK);
         #1;
         if (ADDR_SEND !== 1'b0)
            n++;
      end
      check(25'(n), 25'h0);
   endtask: quiet

   task automatic t_reset();
      RSTN = 1'b0;
      repeat (5) @(posedge SYS_CLK);
      #1;
      check(MODIFIED_DIGIT_OUT, 25'h0);
      check(25'({ADDR_SEND, BUSY}), 25'h0);
      RSTN = 1'b1;
   endtask: t_reset

   // Every request against every value of the low digit.
   task automatic t_digits();
      for (int k = 0; k < 6; k++)
         for (int d = 0; d < 10; d++)
            do_mod(k, {16'h1909, 4'(d)});
   endtask: t_digits

   task automatic t_pretrans();
      logic [19:0] tv [5] = '{20'h00000, 20'h99999, 20'h47290, 20'h00019,
                              20'h12499};
      foreach (tv[i])
      begin
         do_mod(1, tv[i]);
         do_mod(5, tv[i]);
      end
   endtask: t_pretrans

   // A second strobe in mid-hold restarts the hold and replaces the result.
   task automatic t_restart();
      dam_sync_model_i.issue(2, enc(20'h10000));
      quiet(100);
      do_mod(4, 20'h31416);
   endtask: t_restart

   task automatic t_midreset();
      dam_sync_model_i.issue(0, enc(20'h00009));
      quiet(50);
      t_reset();
      quiet(600);
   endtask: t_midreset

   initial
   begin
      t_reset();
      t_digits();
      t_pretrans();
      t_restart();
      t_midreset();
      stop_test();
   end
endmodule: tb_top
